// ==== adm_pkg.sv ====
package adm_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CH0_HI = 12'h0fb2;
	localparam logic [11:0] IDX_CH0_CUR = 12'h0fb3;
	localparam logic [11:0] IDX_CH0_END = 12'h0fb4;
	localparam logic [11:0] IDX_CH1_HI = 12'h0fba;
	localparam logic [11:0] IDX_CH1_CUR = 12'h0fbb;
	localparam logic [11:0] IDX_CH1_END = 12'h0fbc;
	localparam logic [11:0] IDX_ADC_BASE = 12'h0fbd;
	localparam logic [11:0] IDX_ADC_CTL = 12'h0fbe;
	localparam logic [11:0] IDX_STATUS = 12'h0fbf;
	localparam logic [11:0] IDX_GEN_CTL = 12'h0fc0;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h0fc1;
	// field positions
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_ADC_CHANNEL_IRQ_ENABLE_BIT = 6;
	localparam int FLAG_ADC_BIT = 2;
	// reset values and the last legal input
	localparam logic [7:0] ADC_CTL_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [3:0] LAST_LEGAL_IN = 4'hb;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// adc channel write sequencer, gray on each step except the return from ADM_WR_LO to ADM_IDLE
	typedef enum logic [1:0] {
		ADM_IDLE = 2'b00,
		ADM_WR_HI = 2'b01,
		ADM_WR_LO = 2'b11
	} adm_state_t;

	// register file write port
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} adm_rf_wr_t;
endpackage : adm_pkg

// ==== adm_result_mover.sv ====
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1 - each general channel's end address is the high-nibble field above the end low byte.
// RL2 - that 12-bit end address is the last location the general channel reaches.
// RL3 - adc result addresses take their top seven bits from base register bits 7..1.
// RL4 - the five low address bits are the 4-bit input number followed by a zero.
// RL5 - each 10-bit result is written as high byte at the even address, low byte at the odd one.
// RL6 - software keeps base register bit 0 at zero.
// RL7 - with the adc enable clear the channel idles and the input number is held at zero.
// RL8 - with the adc enable set the channel moves conversion results into the register file.
// RL9 - with the adc interrupt enable clear the adc channel raises no interrupt.
// RL10 - with it set an interrupt follows the transfer of the last selected input.
// RL11 - inputs run from 0 upward, codes above 11 acting as 11.
// RL12 - a general channel's current address steps by 1 for bytes or 2 for words.
// RL13 - reading the status register clears all three interrupt flags.
// RL14 - a general channel stops after its transfer at the end address.
// RL15 - while enabled the adc channel wraps to input 0 after the last one.
module adm_result_mover #(
	parameter int RESULT_W = 10
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [13:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic adc_valid,
	input wire logic [RESULT_W-1:0] adc_result,
	output logic adc_ready,
	output logic [3:0] adc_input_sel,
	input wire logic [1:0] gen_req,
	output logic [23:0] gen_cur_addr,
	output logic [11:0] rf_addr,
	output logic [7:0] rf_wdata,
	output logic rf_we,
	output logic irq
);
	// ==========================================================
	// elaboration checks
	if (RESULT_W < 9 || RESULT_W > 16) begin : g_chk
		$error("adm_result_mover: RESULT_W must be 9..16");
	end

	// ==========================================================
	// reset release
	logic rst_meta_ff;
	logic rst_sync_n;
	// two-stage release of the async reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_n <= rst_meta_ff;
		end
	end

	// ==========================================================
	// bus slave
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [7:0] end_lo_ff [2];
	logic [7:0] hi_ff [2];
	logic [11:0] cur_ff [2];
	logic [7:0] base_ff;
	logic [7:0] ctl_ff;
	logic [3:0] gen_ctl_ff;
	logic [2:0] flags_ff;
	logic [2:0] mask_ff;
	logic [3:0] in_ff;
	adm_pkg::adm_state_t state_ff;
	adm_pkg::adm_state_t nxt_state;
	adm_pkg::adm_rf_wr_t rf_ff;
	adm_pkg::adm_rf_wr_t nxt_rf;

	// decode; a request is accepted on the edge where wait is low
	wire req = avs_read | avs_write;
	wire acc = req & ~wait_ff;
	wire wr_acc = avs_write & ~wait_ff;
	wire [11:0] idx = avs_address[13:2];
	wire aligned = avs_address[1:0] == 2'b00;
	wire [7:0] wb = avs_writedata[7:0];
	wire wr_ch0_hi = wr_acc & aligned & (idx == adm_pkg::IDX_CH0_HI);
	wire wr_ch1_hi = wr_acc & aligned & (idx == adm_pkg::IDX_CH1_HI);
	wire wr_ch0_cur = wr_acc & aligned & (idx == adm_pkg::IDX_CH0_CUR);
	wire wr_ch1_cur = wr_acc & aligned & (idx == adm_pkg::IDX_CH1_CUR);
	wire wr_ch0_end = wr_acc & aligned & (idx == adm_pkg::IDX_CH0_END);
	wire wr_ch1_end = wr_acc & aligned & (idx == adm_pkg::IDX_CH1_END);
	wire wr_base = wr_acc & aligned & (idx == adm_pkg::IDX_ADC_BASE);
	wire wr_ctl = wr_acc & aligned & (idx == adm_pkg::IDX_ADC_CTL);
	wire wr_stat = wr_acc & aligned & (idx == adm_pkg::IDX_STATUS);
	wire wr_gctl = wr_acc & aligned & (idx == adm_pkg::IDX_GEN_CTL);
	wire wr_mask = wr_acc & aligned & (idx == adm_pkg::IDX_IRQ_MASK);
	wire rd_stat = avs_read & ~wait_ff & aligned
		& (idx == adm_pkg::IDX_STATUS);
	wire [1:0] wr_hi = {wr_ch1_hi, wr_ch0_hi};
	wire [1:0] wr_cur = {wr_ch1_cur, wr_ch0_cur};
	wire [1:0] wr_end = {wr_ch1_end, wr_ch0_end};

	// read mux, unmapped reads return zero
	wire [7:0] stat_byte = {in_ff, 1'b0, flags_ff};
	wire [7:0] rd_byte =
		!aligned ? adm_pkg::BYTE_RST :
		idx == adm_pkg::IDX_CH0_HI ? hi_ff[0] :
		idx == adm_pkg::IDX_CH0_CUR ? cur_ff[0][7:0] :
		idx == adm_pkg::IDX_CH0_END ? end_lo_ff[0] :
		idx == adm_pkg::IDX_CH1_HI ? hi_ff[1] :
		idx == adm_pkg::IDX_CH1_CUR ? cur_ff[1][7:0] :
		idx == adm_pkg::IDX_CH1_END ? end_lo_ff[1] :
		idx == adm_pkg::IDX_ADC_BASE ? base_ff :
		idx == adm_pkg::IDX_ADC_CTL ? ctl_ff :
		idx == adm_pkg::IDX_STATUS ? stat_byte :
		idx == adm_pkg::IDX_GEN_CTL ? {4'h0, gen_ctl_ff} :
		idx == adm_pkg::IDX_IRQ_MASK ? {5'h00, mask_ff} :
		adm_pkg::BYTE_RST;

	// one wait state, read data captured while waiting
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= adm_pkg::RD_ZERO;
		end else begin
			wait_ff <= ~(req & wait_ff);
			rdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// general channels
	logic [11:0] end_addr [2];
	logic [1:0] at_end;
	logic [1:0] step_go;
	logic [11:0] cur_next [2];
	for (genvar c = 0; c < 2; c++) begin : g_ch
		// end address from high nibble over low byte
		assign end_addr[c] = {hi_ff[c][7:4], end_lo_ff[c]}; // [RL1]
		assign at_end[c] = cur_ff[c] == end_addr[c]; // [RL2]
		assign step_go[c] = gen_req[c] & gen_ctl_ff[2*c];
		// step by one or two bytes
		assign cur_next[c] = cur_ff[c] + (gen_ctl_ff[2*c+1]
			? 12'h002 : 12'h001); // [RL12]
	end

	// address regs and per-channel enable
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int c = 0; c < 2; c++) begin
				end_lo_ff[c] <= adm_pkg::BYTE_RST;
				hi_ff[c] <= adm_pkg::BYTE_RST;
				cur_ff[c] <= 12'h000;
			end
			gen_ctl_ff <= 4'h0;
		end else begin
			if (wr_gctl)
				gen_ctl_ff <= wb[3:0];
			for (int c = 0; c < 2; c++) begin
				if (wr_end[c])
					end_lo_ff[c] <= wb;
				if (wr_hi[c])
					hi_ff[c] <= wb;
				if (step_go[c])
					cur_ff[c] <= cur_next[c]; // [RL12]
				else if (wr_cur[c])
					cur_ff[c][7:0] <= wb;
				else if (wr_hi[c])
					cur_ff[c][11:8] <= wb[3:0];
				if (step_go[c] && at_end[c])
					gen_ctl_ff[2*c] <= 1'b0; // [RL14]
			end
		end
	end

	// ==========================================================
	// adc channel
	wire adc_en = ctl_ff[adm_pkg::CTL_EN_BIT];
	wire adc_adc_channel_irq_enable = ctl_ff[adm_pkg::CTL_ADC_CHANNEL_IRQ_ENABLE_BIT];
	// reserved codes act as the last legal input
	wire [3:0] last_in = ctl_ff[3:0] > adm_pkg::LAST_LEGAL_IN
		? adm_pkg::LAST_LEGAL_IN : ctl_ff[3:0]; // [RL11]
	wire [11:0] slot_addr = {base_ff[7:1], in_ff, 1'b0}; // [RL3] [RL4]
	wire take = adc_valid & adc_en & (state_ff == adm_pkg::ADM_IDLE);
	wire wrap = state_ff == adm_pkg::ADM_WR_LO && in_ff == last_in;
	wire [15:0] res_x = 16'(adc_result);
	logic [7:0] lo_hold_ff;

	// sequencer and write port; disable drops back to idle
	always_comb begin
		nxt_state = state_ff;
		nxt_rf = '{we: 1'b0, addr: rf_ff.addr, data: rf_ff.data};
		case (state_ff)
			adm_pkg::ADM_IDLE: begin
				if (take) begin // [RL8]
					nxt_state = adm_pkg::ADM_WR_HI;
					nxt_rf = '{we: 1'b1, addr: slot_addr,
						data: res_x[15:8]}; // [RL5]
				end
			end
			adm_pkg::ADM_WR_HI: begin
				nxt_state = adm_pkg::ADM_WR_LO;
				nxt_rf = '{we: 1'b1, addr: slot_addr | 12'h001,
					data: lo_hold_ff}; // [RL5]
			end
			adm_pkg::ADM_WR_LO: nxt_state = adm_pkg::ADM_IDLE;
			default: nxt_state = adm_pkg::ADM_IDLE;
		endcase
		// disable aborts a pair in flight, no stray low byte
		if (!adc_en) begin
			nxt_state = adm_pkg::ADM_IDLE; // [RL7]
			nxt_rf.we = 1'b0; // [RL7]
		end
	end

	// state, input counter and captured low byte
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_ff <= adm_pkg::ADM_IDLE;
			rf_ff <= '0;
			in_ff <= 4'h0;
			lo_hold_ff <= adm_pkg::BYTE_RST;
		end else begin
			state_ff <= nxt_state;
			rf_ff <= nxt_rf;
			if (take)
				lo_hold_ff <= res_x[7:0];
			if (!adc_en)
				in_ff <= 4'h0; // [RL7]
			else if (wrap)
				in_ff <= 4'h0; // [RL15]
			else if (state_ff == adm_pkg::ADM_WR_LO)
				in_ff <= in_ff + 4'h1; // [RL11]
		end
	end

	// ==========================================================
	// control, interrupt flags and mask
	wire [2:0] set_ev = {wrap & adc_adc_channel_irq_enable, // [RL9] [RL10]
		step_go[1] & at_end[1], step_go[0] & at_end[0]};
	// status read clears all, write one clears, a new event wins
	wire [2:0] clr_ev = rd_stat ? 3'h7 : (wr_stat ? wb[2:0] : 3'h0);
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			base_ff <= adm_pkg::BYTE_RST;
			ctl_ff <= adm_pkg::ADC_CTL_RST;
			flags_ff <= adm_pkg::FLAGS_RST;
			mask_ff <= adm_pkg::FLAGS_RST;
			irq <= 1'b0;
		end else begin
			if (wr_base)
				base_ff <= wb;
			if (wr_ctl)
				ctl_ff <= wb;
			if (wr_mask)
				mask_ff <= wb[2:0];
			flags_ff <= (flags_ff & ~clr_ev) | set_ev; // [RL13]
			irq <= |(flags_ff & mask_ff);
		end
	end

	// outputs straight from flops
	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign rf_we = rf_ff.we;
	assign rf_addr = rf_ff.addr;
	assign rf_wdata = rf_ff.data;
	assign adc_input_sel = in_ff;
	assign gen_cur_addr = {cur_ff[1], cur_ff[0]};
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			adc_ready <= 1'b0;
		else
			adc_ready <= adc_en & (nxt_state == adm_pkg::ADM_IDLE);
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_n);

	hi_byte_addr_a: assert property ( // [RL3] [RL4]
		state_ff == adm_pkg::ADM_WR_HI |-> rf_we
		&& rf_addr == {base_ff[7:1], in_ff, 1'b0})
		else $error("high byte address wrong");
	lo_follows_a: assert property ( // [RL5]
		rf_we && !rf_addr[0] && adc_en
		|=> rf_we && rf_addr == $past(rf_addr) + 12'h001)
		else $error("low byte not at odd address");
	off_clears_in_a: assert property ( // [RL7]
		!adc_en |=> in_ff == 4'h0 && !rf_we)
		else $error("disabled channel not reset");
	take_writes_a: assert property ( // [RL8]
		take |=> rf_we ##1 rf_we ##1 !rf_we)
		else $error("result not written as two bytes");
	no_irq_off_a: assert property ( // [RL9]
		$rose(flags_ff[adm_pkg::FLAG_ADC_BIT]) |-> $past(adc_adc_channel_irq_enable))
		else $error("adc flag set while irq disabled");
	last_irq_a: assert property ( // [RL10] [RL15]
		wrap && adc_adc_channel_irq_enable && adc_en |=> flags_ff[2] && in_ff == 4'h0)
		else $error("no wrap interrupt");
	seq_step_a: assert property ( // [RL11]
		state_ff == adm_pkg::ADM_WR_LO && !wrap && adc_en
		|=> in_ff == $past(in_ff) + 4'h1)
		else $error("input did not step");
	cur_step_a: assert property ( // [RL12]
		step_go[0] |=> cur_ff[0] == $past(cur_ff[0])
		+ ($past(gen_ctl_ff[1]) ? 12'h002 : 12'h001))
		else $error("current address step wrong");
	end_stop_a: assert property ( // [RL2] [RL14]
		step_go[0] && at_end[0] |=> !gen_ctl_ff[0] && flags_ff[0])
		else $error("channel ran past end");
	read_clear_a: assert property ( // [RL13]
		rd_stat && set_ev == 3'h0 |=> flags_ff == 3'h0)
		else $error("status read did not clear");

	wrap_c: cover property (wrap ##1 in_ff == 4'h0);
	end_c: cover property (step_go[1] && at_end[1]);
	rd_c: cover property (rd_stat && flags_ff != 3'h0);
	irq_c: cover property ($rose(irq));
endmodule : adm_result_mover

`default_nettype wire

// ==== adm_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// converter and register file stand-in
module adm_adc_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pause,
	input wire logic adc_ready,
	input wire logic [11:0] rf_addr,
	input wire logic [7:0] rf_wdata,
	input wire logic rf_we,
	output logic adc_valid,
	output logic [9:0] adc_result
);
	int gap;
	logic [7:0] mem [4096];

	// one-cycle result strobe, random gap, data inverted once released
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_valid <= 1'b0;
			adc_result <= 10'h155;
			gap <= 0;
		end else begin
			adc_valid <= 1'b0;
			if (adc_valid) adc_result <= ~adc_result;
			if (adc_ready && !adc_valid && !pause) begin
				if (gap == 0) begin
					adc_valid <= 1'b1;
					adc_result <= 10'($urandom % 1024);
					gap <= int'($urandom % 4);
				end else gap <= gap - 1;
			end
		end
	end

	// byte storage of the register file
	always @(posedge ref_clk) begin
		if (rf_we) mem[rf_addr] <= rf_wdata;
	end
endmodule : adm_adc_model

`default_nettype wire

// ==== adm_result_mover_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// bench top
module adm_result_mover_tb_top;
	logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, pause;
	logic [13:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic adc_valid, adc_ready, rf_we, irq;
	logic [9:0] adc_result;
	logic [3:0] adc_input_sel;
	logic [1:0] gen_req;
	logic [23:0] gen_cur_addr;
	logic [11:0] rf_addr, qa[$];
	logic [7:0] rf_wdata, rd, base, qd[$];
	int fails, cmp_count, cyc, in_n, last_eff, nres, cur[2], endv[2];
	bit flag_a, adc_channel_irq_enable, gen_en[2], done[2];

	adm_result_mover dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.adc_valid(adc_valid), .adc_result(adc_result),
		.adc_ready(adc_ready), .adc_input_sel(adc_input_sel),
		.gen_req(gen_req), .gen_cur_addr(gen_cur_addr), .rf_addr(rf_addr),
		.rf_wdata(rf_wdata), .rf_we(rf_we), .irq(irq));
	adm_adc_model adc (.ref_clk(ref_clk), .rst_n(rst_n), .pause(pause),
		.adc_ready(adc_ready), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
		.rf_we(rf_we), .adc_valid(adc_valid), .adc_result(adc_result));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [11:0] e,
		input logic [11:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task complete_run;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// one bus transfer, held until waitrequest is sampled low
	task automatic bus(input bit wr, input logic [11:0] idx,
		input logic [7:0] wd, output logic [7:0] rd_o);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h00_0000, wd};
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd_o = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask : bus

	task automatic wr_ctl(input logic [7:0] v);
		bus(1'b1, adm_pkg::IDX_ADC_CTL, v, rd);
		last_eff = (v[3:0] > 4'hb) ? 11 : int'(v[3:0]);
		adc_channel_irq_enable = v[6];
		if (!v[7]) in_n = 0;
	endtask : wr_ctl

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	// result model: expected writes, input sequence, completion flag
	always @(posedge ref_clk) begin
		if (adc_valid && adc_ready) begin
			qa.push_back({base[7:1], 4'(in_n), 1'b0});
			qa.push_back({base[7:1], 4'(in_n), 1'b1});
			qd.push_back({6'h00, adc_result[9:8]});
			qd.push_back(adc_result[7:0]);
			if (in_n == last_eff) flag_a |= adc_channel_irq_enable;
			in_n = (in_n == last_eff) ? 0 : in_n + 1;
			nres++;
		end
		if (rf_we === 1'b1) begin
			if (qa.size() == 0) chk("rf_we", 12'h000, 12'h001);
			else begin
				chk("rf_addr", qa.pop_front(), rf_addr);
				chk("rf_wdata", qd.pop_front(), rf_wdata);
			end
		end
	end

	initial begin
		void'($urandom(45));
		rst_n = 1'b0;
		{avs_read, avs_write, pause, gen_req} = '0;
		avs_address = '0;
		avs_writedata = '0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		bus(1'b0, adm_pkg::IDX_ADC_CTL, 8'h00, rd);
		chk("ctl_reset", 12'h000, rd);
		bus(1'b0, 12'h000, 8'h00, rd);
		chk("unmapped", 12'h000, rd);
		bus(1'b1, adm_pkg::IDX_IRQ_MASK, 8'h07, rd);
		// adc runs: new base and last input each time, last one without irq
		for (int k = 0; k < 4; k++) begin
			pause <= 1'b1;
			base = 8'($urandom % 256) & 8'hfe;
			bus(1'b1, adm_pkg::IDX_ADC_BASE, base, rd);
			wr_ctl(8'h80 | ((k < 3) ? 8'h40 : 8'h00) | 8'($urandom % 16));
			nres = 0;
			pause <= 1'b0;
			wait (nres >= 2 * (last_eff + 1) + 1);
			pause <= 1'b1;
			repeat (8) @(posedge ref_clk);
			chk("irq", 12'(flag_a), 12'(irq));
			chk("queue", 12'h000, 12'(qa.size()));
			wr_ctl({1'b0, adc_channel_irq_enable, 6'(last_eff)});
			repeat (2) @(posedge ref_clk);
			chk("input_sel", 12'h000, 12'(adc_input_sel));
			bus(1'b0, adm_pkg::IDX_STATUS, 8'h00, rd);
			chk("status", {9'h000, flag_a, 2'b00}, rd);
			flag_a = 0;
			repeat (2) @(posedge ref_clk);
			chk("irq_clear", 12'h000, 12'(irq));
			bus(1'b0, adm_pkg::IDX_STATUS, 8'h00, rd);
			chk("status_clear", 12'h000, rd);
		end
		// general channels: ch0 words 1f0..1f4, ch1 bytes 3fd..401
		bus(1'b1, adm_pkg::IDX_CH0_HI, 8'h11, rd);
		bus(1'b1, adm_pkg::IDX_CH0_CUR, 8'hf0, rd);
		bus(1'b1, adm_pkg::IDX_CH0_END, 8'hf4, rd);
		bus(1'b1, adm_pkg::IDX_CH1_HI, 8'h43, rd);
		bus(1'b1, adm_pkg::IDX_CH1_CUR, 8'hfd, rd);
		bus(1'b1, adm_pkg::IDX_CH1_END, 8'h01, rd);
		bus(1'b1, adm_pkg::IDX_GEN_CTL, 8'h07, rd);
		cur = '{12'h1f0, 12'h3fd};
		endv = '{12'h1f4, 12'h401};
		gen_en = '{1, 1};
		repeat (40) begin
			gen_req <= 2'($urandom % 4);
			@(posedge ref_clk);
			for (int c = 0; c < 2; c++) begin
				if (gen_req[c] && gen_en[c]) begin
					if (cur[c] == endv[c]) {gen_en[c], done[c]} = 2'b01;
					cur[c] = (cur[c] + ((c == 0) ? 2 : 1)) % 4096;
				end
			end
			gen_req <= 2'b00;
			@(posedge ref_clk);
			chk("ch0_cur", 12'(cur[0]), gen_cur_addr[11:0]);
			chk("ch1_cur", 12'(cur[1]), gen_cur_addr[23:12]);
		end
		bus(1'b0, adm_pkg::IDX_STATUS, 8'h00, rd);
		chk("gen_flags", {10'h000, done[1], done[0]}, rd & 8'h03);
		complete_run();
	end
endmodule : adm_result_mover_tb_top

`default_nettype wire
